// ### bench/bba_ref_timebase.sv
// reference timebase model: per output line count and frame pulse
// assumes one line per clock, so frames stay short in simulation
`timescale 1ns/1ps
module bba_ref_timebase #(
    parameter int LINES = 24
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    output logic [3:0] o_frame_start,
    output logic [3:0][10:0] o_line_num
);
    // ------------------------------------------------------------
    // line counters
    // ------------------------------------------------------------
    // staggered so that outputs never share a frame edge
    always_ff @(posedge i_clk) begin
        for (int g = 0; g < 4; g++) begin
            if (i_sys_rst) begin
                o_line_num[g] <= 11'(1 + 5 * g);
                o_frame_start[g] <= 1'b0;
            end else if (o_line_num[g] == 11'(LINES)) begin
                o_line_num[g] <= 11'h001;
                o_frame_start[g] <= 1'b1;
            end else begin
                o_line_num[g] <= o_line_num[g] + 11'h001;
                o_frame_start[g] <= 1'b0;
            end
        end
    end
endmodule : bba_ref_timebase

// ### bench/bba_top_bench.sv
// self-checking bench for the black burst extras block
// assumes the timebase model drives frame pulses and line numbers
`timescale 1ns/1ps
`include "bba_cfg.svh"
module bba_top_bench;
    import bba_pkg::*;
    logic clk = 1'b0;
    logic rst;
    logic [7:0] i_addr;
    logic [31:0] i_wdata;
    logic i_wr;
    logic i_rd;
    logic [31:0] o_rdata;
    logic [3:0] fs;
    logic [3:0] hd;
    logic [3:0][10:0] ln;
    bba_active_s [3:0] act;
    logic [3:0] tr_slot;
    logic [3:0] tc_slot;
    bba_active_s rst_act;
    bba_active_s e;
    int bad_count = 0;
    int num_checks = 0;

    always #25 clk = ~clk;

    bba_top u_bba_top (.i_clk(clk), .i_sys_rst(rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_frame_start(fs), .i_hd_restricted(hd), .i_line_num(ln),
        .o_active(act), .o_timeref_slot(tr_slot), .o_vitc_slot(tc_slot));
    bba_ref_timebase u_bba_ref_timebase (.i_clk(clk), .i_sys_rst(rst),
        .o_frame_start(fs), .o_line_num(ln));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge clk);
        i_wr <= 1'b0;
    endtask : wr
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge clk);
        i_rd <= 1'b0;
        #1;
        chk(64'(o_rdata), 64'(exp));
    endtask : rd
    task automatic frame(input int g);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (fs[g] !== 1'b1 && n < 100);
        // a missing frame pulse counts as a mismatch
        if (fs[g] !== 1'b1) bad_count++;
        #1;
    endtask : frame
    // line value is taken before the timebase updates at that edge
    task automatic slots(input int g, input logic tr, input logic tc,
                         input logic [10:0] f, input logic [10:0] s);
        logic [10:0] l;
        repeat (24) begin
            @(posedge clk);
            l = ln[g];
            #1;
            chk(64'(tr_slot[g]), 64'(tr && l == 11'h00c));
            chk(64'(tc_slot[g]), 64'(tc && (l == f || l == s)
                && !(tr && l == 11'h00c)));
        end
    endtask : slots

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        for (int g = 0; g < 4; g++) chk(64'(act[g]), 64'(rst_act));
        rd(`BBA_REG_VITC, 32'h0000100e);
        rd(`BBA_REG_APPLIED, 32'h00000000);
        rd(8'h20, 32'h00000000);
        wr(8'h20, 32'hffffffff);
        rd(`BBA_REG_STATUS, 32'h00000000);
    endtask : t_reset
    task automatic t_flags();
        wr(`BBA_REG_SEL, 32'h00000001);
        frame(1);
        wr(`BBA_REG_CTRL, 32'h0000003f);
        chk(64'(act[1]), 64'(rst_act));
        frame(1);
        e = rst_act;
        e.output_enable = 1'b1;
        e.ten_field = 1'b1;
        e.setup = 1'b1;
        e.timeref_insert = 1'b1;
        e.timecode_insert = 1'b1;
        e.tracking = tracking_by_offset;
        chk(64'(act[1]), 64'(e));
        chk(64'(act[0]), 64'(rst_act));
        rd(`BBA_REG_STATUS, 32'h0000003f);
    endtask : t_flags
    // every tracking code, code 3 refused
    task automatic t_track();
        for (int k = 0; k < 4; k++) begin
            wr(`BBA_REG_CTRL, 32'h1f | 32'(k << 5));
            frame(1);
            chk(64'(act[1].tracking), (k == 3) ? 64'h2 : 64'(k));
        end
    endtask : t_track
    task automatic t_offset();
        wr(`BBA_REG_OFFSET, 32'h2098967f);
        rd(`BBA_REG_OFFSET, 32'h2098967f);
        wr(`BBA_REG_OFFSET, 32'h00989680);
        rd(`BBA_REG_OFFSET, 32'h2098967f);
        wr(`BBA_REG_OFFSET, 32'h11676981);
        wr(`BBA_REG_OFFSET, 32'h01676980);
        rd(`BBA_REG_OFFSET, 32'h9f676981);
        frame(1);
        rd(`BBA_REG_APPLIED, 32'h00000000);
        wr(`BBA_REG_CTRL, 32'h000000bf);
        frame(1);
        rd(`BBA_REG_APPLIED, 32'hff676981);
        chk(64'(act[1].offset_unit), 64'h1);
        wr(`BBA_REG_CTRL, 32'h0000003f);
        wr(`BBA_REG_OFFSET, 32'h2098967f);
        frame(1);
        rd(`BBA_REG_APPLIED, 32'hff676981);
    endtask : t_offset
    task automatic t_lines();
        wr(`BBA_REG_VITC, 32'h0000140a);
        wr(`BBA_REG_VITC, 32'h00001409);
        wr(`BBA_REG_VITC, 32'h0000150a);
        rd(`BBA_REG_VITC, 32'h0000140a);
        frame(1);
        slots(1, 1'b1, 1'b1, 11'h00a, 11'h014);
        wr(`BBA_REG_VITC, 32'h00000c0c);
        frame(1);
        slots(1, 1'b1, 1'b1, 11'h00c, 11'h00c);
        wr(`BBA_REG_CTRL, 32'h00000037);
        frame(1);
        slots(1, 1'b0, 1'b1, 11'h00c, 11'h00c);
    endtask : t_lines
    // restricted standard or disabled output drops extras
    task automatic t_hd();
        wr(`BBA_REG_CTRL, 32'h0000003f);
        @(posedge clk);
        hd[1] <= 1'b1;
        frame(1);
        chk(64'({act[1].ten_field, act[1].setup, act[1].timeref_insert,
            act[1].timecode_insert, act[1].tracking}), 64'h0);
        slots(1, 1'b0, 1'b0, 11'h00c, 11'h00c);
        @(posedge clk);
        hd[1] <= 1'b0;
        frame(1);
        chk(64'(act[1].ten_field), 64'h1);
        wr(`BBA_REG_CTRL, 32'h0000003e);
        frame(1);
        chk(64'({act[1].ten_field, act[1].setup, act[1].timeref_insert,
            act[1].timecode_insert, act[1].tracking}), 64'h0);
    endtask : t_hd

    task automatic close_out();
        if (bad_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out

    initial begin
        rst = 1'b1;
        i_addr = 8'h00;
        i_wdata = 32'h00000000;
        i_wr = 1'b0;
        i_rd = 1'b0;
        hd = 4'h0;
        rst_act = '0;
        rst_act.line_first = 5'h0e;
        rst_act.line_second = 5'h10;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_flags();
        t_track();
        t_offset();
        t_lines();
        t_hd();
        close_out();
    end

    // run needs about 460 cycles
    initial begin
        repeat (6000) @(posedge clk);
        bad_count++;
        close_out();
    end
endmodule : bba_top_bench

// ### core/bba_cfg.svh
// constants for the black burst extras block: offsets, fields, resets
// assumes byte addresses on a 32-bit register port
`ifndef BBA_CFG_SVH
`define BBA_CFG_SVH

`define BBA_NUM_OUT 4
`define BBA_SEL_W 2
`define BBA_ADDR_W 8

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define BBA_REG_SEL 8'h00
`define BBA_REG_CTRL 8'h04
`define BBA_REG_OFFSET 8'h08
`define BBA_REG_VITC 8'h0c
`define BBA_REG_APPLIED 8'h10
`define BBA_REG_STATUS 8'h14

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BBA_CTRL_EN 0
`define BBA_CTRL_TENF 1
`define BBA_CTRL_SETUP 2
`define BBA_CTRL_TREF 3
`define BBA_CTRL_TCODE 4
`define BBA_CTRL_TRACK_LO 5
`define BBA_CTRL_APPLY 7
`define BBA_OFS_W 25
`define BBA_OFS_UNIT_LO 28
`define BBA_VITC2_LO 8

// ----------------------------------------------------------------
// limits and reset values
// ----------------------------------------------------------------
`define BBA_OFS_MAX 25'sh098967f
`define BBA_OFS_MIN (-25'sh098967f)
`define BBA_VITC_MIN 5'h0a
`define BBA_VITC_MAX 5'h14
`define BBA_VITC1_RST 5'h0e
`define BBA_VITC2_RST 5'h10
`define BBA_TIMEREF_LINE 11'h00c
`define BBA_TRACK_BAD 2'h3

`endif

// ### core/bba_pkg.sv
// types shared by the black burst extras block
// assumes the constants header sits beside it
package bba_pkg;

    typedef enum logic [1:0] {
        tracking_off,
        tracking_by_offset,
        tracking_by_time
    } bba_track_e;

    // settings as software last wrote them
    typedef struct packed {
        logic output_enable;
        logic ten_field_enable;
        logic setup_pedestal_enable;
        logic timeref_insert_enable;
        logic timecode_insert_enable;
        bba_track_e timeref_tracking_mode;
        logic offset_apply_now;
        logic signed [24:0] timeref_offset_value;
        logic [2:0] offset_unit;
        logic [4:0] timecode_line_first;
        logic [4:0] timecode_line_second;
    } bba_cfg_s;

    // settings in force for the current frame
    typedef struct packed {
        logic output_enable;
        logic ten_field;
        logic setup;
        logic timeref_insert;
        logic timecode_insert;
        bba_track_e tracking;
        logic signed [24:0] applied_offset_readback;
        logic [2:0] offset_unit;
        logic [4:0] line_first;
        logic [4:0] line_second;
    } bba_active_s;

endpackage : bba_pkg

// ### core/bba_range_chk.sv
// range checks on register write data
// assumes the data word layout of the constants header
`timescale 1ns/1ps
`include "bba_cfg.svh"

module bba_range_chk (
    input wire logic [31:0] i_wdata,
    output logic o_offset_ok,
    output logic o_lines_ok
);
    import bba_pkg::*;

    logic signed [24:0] ofs;
    logic [4:0] ln1;
    logic [4:0] ln2;

    assign ofs = i_wdata[`BBA_OFS_W-1:0];
    assign ln1 = i_wdata[4:0];
    assign ln2 = i_wdata[`BBA_VITC2_LO +: 5];

    assign o_offset_ok = (ofs <= `BBA_OFS_MAX) && (ofs >= `BBA_OFS_MIN);
    assign o_lines_ok = (ln1 >= `BBA_VITC_MIN) && (ln1 <= `BBA_VITC_MAX)
        && (ln2 >= `BBA_VITC_MIN) && (ln2 <= `BBA_VITC_MAX);

endmodule : bba_range_chk

// ### core/bba_shadow.sv
// per-output shadow: takes pending settings at each frame start
// assumes frame start and line number come from the local timebase
`timescale 1ns/1ps
`include "bba_cfg.svh"

module bba_shadow (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_frame_start,
    input wire logic i_hd_restricted,
    input wire logic [10:0] i_line_num,
    input bba_pkg::bba_cfg_s i_pend,
    output bba_pkg::bba_active_s o_active,
    output logic o_timeref_slot,
    output logic o_vitc_slot
);
    import bba_pkg::*;

    bba_active_s act;
    bba_active_s next_act;
    logic next_tslot;
    logic next_vslot;
    logic allow;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_act = act;
        allow = i_pend.output_enable && !i_hd_restricted;
        if (i_frame_start) begin
            next_act.output_enable = i_pend.output_enable;
            next_act.ten_field = allow && i_pend.ten_field_enable;
            next_act.setup = allow && i_pend.setup_pedestal_enable;
            next_act.timeref_insert = allow && i_pend.timeref_insert_enable;
            next_act.timecode_insert = allow && i_pend.timecode_insert_enable;
            // tracking falls back to off when barred
            next_act.tracking = allow ? i_pend.timeref_tracking_mode
                : tracking_off;
            next_act.offset_unit = i_pend.offset_unit;
            next_act.line_first = i_pend.timecode_line_first;
            next_act.line_second = i_pend.timecode_line_second;
            // offset moves only with apply set
            if (i_pend.offset_apply_now) begin
                next_act.applied_offset_readback =
                    i_pend.timeref_offset_value;
            end
        end
        // line 12 held for time reference
        next_tslot = act.timeref_insert
            && (i_line_num == `BBA_TIMEREF_LINE);
        // timecode on either line, never on line 12 while time reference is inserted
        next_vslot = act.timecode_insert && !next_tslot
            && ((i_line_num == {6'h00, act.line_first})
            || (i_line_num == {6'h00, act.line_second}));
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            act <= '0;
            act.line_first <= `BBA_VITC1_RST;
            act.line_second <= `BBA_VITC2_RST;
            o_timeref_slot <= 1'b0;
            o_vitc_slot <= 1'b0;
        end else begin
            act <= next_act;
            o_timeref_slot <= next_tslot;
            o_vitc_slot <= next_vslot;
        end
    end

    assign o_active = act;

endmodule : bba_shadow

// ### core/bba_top.sv
// black burst extras: register port, per-output settings, shadows
// assumes a single-cycle register master and a timebase on i_clk
//
// Operation
// - ten-field sequence flag per output
// - 7.5 IRE setup pedestal per output
// - line 12 reserved for time reference
// - three tracking modes: off, offset, time
// - signed offset within +/-9999999 plus unit
// - offset applies only with apply-now set
// - read-only applied offset readback
// - timecode inserted when enabled
// - first timecode line limited to 10..20
// - each output keeps its own settings
// - restricted HD standards disable the extras
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "bba_cfg.svh"

module bba_top (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [`BBA_ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic [`BBA_NUM_OUT-1:0] i_frame_start,
    input wire logic [`BBA_NUM_OUT-1:0] i_hd_restricted,
    input wire logic [`BBA_NUM_OUT-1:0][10:0] i_line_num,
    output bba_pkg::bba_active_s [`BBA_NUM_OUT-1:0] o_active,
    output logic [`BBA_NUM_OUT-1:0] o_timeref_slot,
    output logic [`BBA_NUM_OUT-1:0] o_vitc_slot
);
    import bba_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [`BBA_SEL_W-1:0] sel;
    logic [`BBA_SEL_W-1:0] next_sel;
    bba_cfg_s [`BBA_NUM_OUT-1:0] pend;
    bba_cfg_s [`BBA_NUM_OUT-1:0] next_pend;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic offset_ok;
    logic lines_ok;
    bba_cfg_s cur;
    bba_active_s cur_act;

    assign cur = pend[sel];
    assign cur_act = o_active[sel];

    bba_range_chk u_range (
        .i_wdata(i_wdata),
        .o_offset_ok(offset_ok),
        .o_lines_ok(lines_ok)
    );

    // ----------------------------------------------------------------
    // register writes and reads
    // ----------------------------------------------------------------
    always_comb begin
        next_sel = sel;
        next_pend = pend;
        next_rdata = 32'h0000_0000;
        if (i_wr) begin
            case (i_addr)
                `BBA_REG_SEL: begin
                    next_sel = i_wdata[`BBA_SEL_W-1:0];
                end
                // writes land in the selected copy only
                `BBA_REG_CTRL: begin
                    next_pend[sel].output_enable = i_wdata[`BBA_CTRL_EN];
                    next_pend[sel].ten_field_enable =
                        i_wdata[`BBA_CTRL_TENF];
                    next_pend[sel].setup_pedestal_enable =
                        i_wdata[`BBA_CTRL_SETUP];
                    next_pend[sel].timeref_insert_enable =
                        i_wdata[`BBA_CTRL_TREF];
                    next_pend[sel].timecode_insert_enable =
                        i_wdata[`BBA_CTRL_TCODE];
                    next_pend[sel].offset_apply_now =
                        i_wdata[`BBA_CTRL_APPLY];
                    // unused mode code leaves mode as it was
                    if (i_wdata[`BBA_CTRL_TRACK_LO +: 2]
                        != `BBA_TRACK_BAD) begin
                        next_pend[sel].timeref_tracking_mode =
                            bba_track_e'(i_wdata[`BBA_CTRL_TRACK_LO +: 2]);
                    end
                end
                `BBA_REG_OFFSET: begin
                    if (offset_ok) begin
                        next_pend[sel].timeref_offset_value =
                            i_wdata[`BBA_OFS_W-1:0];
                        next_pend[sel].offset_unit =
                            i_wdata[`BBA_OFS_UNIT_LO +: 3];
                    end
                end
                // line pair written together or not at all
                `BBA_REG_VITC: begin
                    if (lines_ok) begin
                        next_pend[sel].timecode_line_first = i_wdata[4:0];
                        next_pend[sel].timecode_line_second =
                            i_wdata[`BBA_VITC2_LO +: 5];
                    end
                end
                default: begin
                end
            endcase
        end
        if (i_rd) begin
            case (i_addr)
                `BBA_REG_SEL: begin
                    next_rdata[`BBA_SEL_W-1:0] = sel;
                end
                `BBA_REG_CTRL: begin
                    next_rdata[`BBA_CTRL_EN] = cur.output_enable;
                    next_rdata[`BBA_CTRL_TENF] = cur.ten_field_enable;
                    next_rdata[`BBA_CTRL_SETUP] = cur.setup_pedestal_enable;
                    next_rdata[`BBA_CTRL_TREF] = cur.timeref_insert_enable;
                    next_rdata[`BBA_CTRL_TCODE] = cur.timecode_insert_enable;
                    next_rdata[`BBA_CTRL_TRACK_LO +: 2] =
                        cur.timeref_tracking_mode;
                    next_rdata[`BBA_CTRL_APPLY] = cur.offset_apply_now;
                end
                `BBA_REG_OFFSET: begin
                    next_rdata = {{7{cur.timeref_offset_value[24]}},
                        cur.timeref_offset_value};
                    next_rdata[`BBA_OFS_UNIT_LO +: 3] = cur.offset_unit;
                end
                `BBA_REG_VITC: begin
                    next_rdata[4:0] = cur.timecode_line_first;
                    next_rdata[`BBA_VITC2_LO +: 5] = cur.timecode_line_second;
                end
                `BBA_REG_APPLIED: begin
                    next_rdata = {{7{cur_act.applied_offset_readback[24]}},
                        cur_act.applied_offset_readback};
                end
                // flags in force this frame, after any HD gating
                `BBA_REG_STATUS: begin
                    next_rdata[`BBA_CTRL_EN] = cur_act.output_enable;
                    next_rdata[`BBA_CTRL_TENF] = cur_act.ten_field;
                    next_rdata[`BBA_CTRL_SETUP] = cur_act.setup;
                    next_rdata[`BBA_CTRL_TREF] = cur_act.timeref_insert;
                    next_rdata[`BBA_CTRL_TCODE] = cur_act.timecode_insert;
                    next_rdata[`BBA_CTRL_TRACK_LO +: 2] = cur_act.tracking;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            sel <= '0;
            rdata <= 32'h0000_0000;
            for (int i = 0; i < `BBA_NUM_OUT; i++) begin
                pend[i] <= '0;
                pend[i].timecode_line_first <= `BBA_VITC1_RST;
                pend[i].timecode_line_second <= `BBA_VITC2_RST;
            end
        end else begin
            sel <= next_sel;
            pend <= next_pend;
            rdata <= next_rdata;
        end
    end

    assign o_rdata = rdata;

    // ----------------------------------------------------------------
    // per-output shadows
    // ----------------------------------------------------------------
    for (genvar g = 0; g < `BBA_NUM_OUT; g++) begin : g_out
        bba_shadow u_shadow (
            .i_clk(i_clk),
            .i_sys_rst(i_sys_rst),
            .i_frame_start(i_frame_start[g]),
            .i_hd_restricted(i_hd_restricted[g]),
            .i_line_num(i_line_num[g]),
            .i_pend(pend[g]),
            .o_active(o_active[g]),
            .o_timeref_slot(o_timeref_slot[g]),
            .o_vitc_slot(o_vitc_slot[g])
        );

        // ------------------------------------------------------------
        // checks per output
        // ------------------------------------------------------------
        chk_tenf_load: assert property (
            @(posedge i_clk) disable iff (i_sys_rst)
            i_frame_start[g] ##1 1'b1 |->
                o_active[g].ten_field == ($past(pend[g].ten_field_enable)
                && $past(pend[g].output_enable)
                && !$past(i_hd_restricted[g])))
            else $error("ten-field flag not loaded at frame start");

        chk_setup_load: assert property (
            @(posedge i_clk) disable iff (i_sys_rst)
            i_frame_start[g] && pend[g].setup_pedestal_enable
                && pend[g].output_enable && !i_hd_restricted[g]
                |=> o_active[g].setup)
            else $error("setup pedestal not taken at frame start");

        chk_line12_only: assert property (
            @(posedge i_clk) disable iff (i_sys_rst)
            o_timeref_slot[g] |-> !o_vitc_slot[g]
                && $past(i_line_num[g]) == `BBA_TIMEREF_LINE)
            else $error("line 12 not kept for time reference");

        chk_track_legal: assert property (
            @(posedge i_clk) disable iff (i_sys_rst)
            o_active[g].tracking != `BBA_TRACK_BAD
                && pend[g].timeref_tracking_mode != `BBA_TRACK_BAD)
            else $error("tracking mode holds unused code");

        chk_apply_gate: assert property (
            @(posedge i_clk) disable iff (i_sys_rst)
            !(i_frame_start[g] && pend[g].offset_apply_now)
                ##1 !$past(i_sys_rst)
                |-> $stable(o_active[g].applied_offset_readback))
            else $error("offset changed without apply");

        chk_vitc_enable: assert property (
            @(posedge i_clk) disable iff (i_sys_rst)
            o_vitc_slot[g] |-> $past(o_active[g].timecode_insert, 1))
            else $error("timecode slot while insertion off");

        chk_vitc_lines: assert property (
            @(posedge i_clk) disable iff (i_sys_rst)
            o_vitc_slot[g] |-> $past(i_line_num[g] == {6'h00,
                o_active[g].line_first} || i_line_num[g] == {6'h00,
                o_active[g].line_second}))
            else $error("timecode slot on a line not chosen");

        chk_vitc_window: assert property (
            @(posedge i_clk) disable iff (i_sys_rst)
            pend[g].timecode_line_first >= `BBA_VITC_MIN
                && pend[g].timecode_line_first <= `BBA_VITC_MAX
                && pend[g].timecode_line_second >= `BBA_VITC_MIN
                && pend[g].timecode_line_second <= `BBA_VITC_MAX)
            else $error("timecode line outside 10 to 20");

        chk_offset_range: assert property (
            @(posedge i_clk) disable iff (i_sys_rst)
            pend[g].timeref_offset_value <= `BBA_OFS_MAX
                && pend[g].timeref_offset_value >= `BBA_OFS_MIN)
            else $error("stored offset outside magnitude limits");

        chk_hd_gate: assert property (
            @(posedge i_clk) disable iff (i_sys_rst)
            i_frame_start[g] && i_hd_restricted[g] |=>
                !o_active[g].ten_field && !o_active[g].setup
                && !o_active[g].timeref_insert
                && !o_active[g].timecode_insert)
            else $error("extras left on for restricted standard");

        chk_frame_hold: assert property (
            @(posedge i_clk) disable iff (i_sys_rst)
            !i_frame_start[g] ##1 !$past(i_sys_rst)
                |-> $stable(o_active[g]))
            else $error("active settings changed mid-frame");
    end

    // ----------------------------------------------------------------
    // checks on the register port
    // ----------------------------------------------------------------
    chk_readback_val: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        i_rd && i_addr == `BBA_REG_APPLIED |=>
            o_rdata[`BBA_OFS_W-1:0]
            == $past(o_active[sel].applied_offset_readback))
        else $error("applied offset readback mismatch");

    chk_bad_line_drop: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        i_wr && i_addr == `BBA_REG_VITC && !lines_ok
            |=> $stable(pend))
        else $error("out-of-window line write was taken");

    chk_offset_drop: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        i_wr && i_addr == `BBA_REG_OFFSET && !offset_ok
            |=> $stable(pend))
        else $error("out-of-range offset write was taken");

    chk_rdata_idle: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        !i_rd |=> o_rdata == 32'h0000_0000)
        else $error("read data held past its cycle");

    chk_sel_isolate: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        i_wr && i_addr == `BBA_REG_CTRL ##0 sel != 2'h0
            |=> $stable(pend[0]))
        else $error("write to one output touched another");

    chk_unmapped_zero: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        i_rd && i_addr > `BBA_REG_STATUS |=> o_rdata == 32'h0000_0000)
        else $error("unmapped read not zero");

endmodule : bba_top
